// file: alu_if.sv
// Operand and result bundle between the execute block and the adder.
`timescale 1ns/1ps
`default_nettype none
interface alu_if;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [7:0] sum;
    logic       cout;
    logic       dc;
    modport master (output a, output b, output cin, input sum, input cout, input dc);
    modport slave  (input a, input b, input cin, output sum, output cout, output dc);
endinterface
`default_nettype wire

// file: exec_defs.svh
// Constants for the subtract, swap, special-register and halt execute block.
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH
`define SPECIAL_SEL_MIN 4'h7
`define SPECIAL_SEL_MAX 4'hf
`define FILE_ADDR_MAX   6'h3f
`define ACC_RESET       8'h00
`define FILE_RESET      8'h00
`define SPECIAL_RESET   8'h00
`define WDT_CLEAR       8'h00
`define FLAG_TO_RESET   1'b1
`define FLAG_PD_RESET   1'b1
`endif

// file: exec_pkg.sv
// Types shared by the execute block, its assertion checker and its bench.
package exec_pkg;
    typedef enum logic [2:0]
    {
        OP_NONE         = 3'h0,
        OP_SUB_IMM_BRW  = 3'h1,
        OP_LOAD_SPECIAL = 3'h2,
        OP_STORE_SPEC   = 3'h3,
        OP_HALT_ENTRY   = 3'h4,
        OP_SUB_ACC_FILE = 3'h5,
        OP_NIBBLE_EXCH  = 3'h6
    } op_t;
    typedef enum logic [1:0]
    {
        ST_RUN    = 2'b00,
        ST_HALTED = 2'b01
    } core_state_t;
endpackage

// file: sub_adder.sv
// Adder forming a + ~b + cin with carry out and digit carry.
`timescale 1ns/1ps
`default_nettype none
module sub_adder
(
    alu_if.slave port
);
    logic [4:0] low;
    logic [4:0] high;
    // Carry 1 means no borrow; digit carry is the carry out of bit 3.
    always_comb
    begin
        low  = {1'b0, port.a[3:0]} + {1'b0, ~port.b[3:0]} + {4'h0, port.cin};
        high = {1'b0, port.a[7:4]} + {1'b0, ~port.b[7:4]} + {4'h0, low[4]};
        port.sum  = {high[3:0], low[3:0]};
        port.cout = high[4];
        port.dc   = low[4];
    end
endmodule
`default_nettype wire

// file: subtract_swap_exec.sv
// Execute stage for subtract, nibble swap, special-register moves and halt entry.
// Notes on behaviour
// - Immediate plus inverted accumulator plus carry to accumulator.
// - Special register 7..15 copied to accumulator, flags kept.
// - Accumulator stored to special register 7..15, flags kept.
// - Halt clears watchdog counter and prescaler in one cycle.
// - Halt sets timeout flag, clears powerdown flag, stops.
// - File minus accumulator to chosen destination, flags updated.
// - Nibble swap of file register, flags untouched.
`timescale 1ns/1ps
`default_nettype none
`include "exec_defs.svh"
module subtract_swap_exec
    import exec_pkg::*;
#(
    parameter int FILE_DEPTH = 64
)
(
    input  wire logic       clk_sys_i,
    input  wire logic       rst_i,
    input  wire logic       op_valid_i,
    input  wire op_t        op_i,
    input  wire logic [7:0] imm_i,
    input  wire logic [5:0] file_addr_i,
    input  wire logic       dest_file_i,
    input  wire logic [3:0] special_sel_i,
    input  wire logic       wake_i,
    output logic [7:0]      accumulator_o,
    output logic            zero_flag_o,
    output logic            digit_carry_flag_o,
    output logic            carry_flag_o,
    output logic            timeout_flag_n_o,
    output logic            powerdown_flag_n_o,
    output logic            halted_o,
    output logic            wdt_clear_o,
    output logic [7:0]      watchdog_count_o,
    output logic [7:0]      watchdog_prescaler_o,
    output logic            illegal_op_o
);
    // The file address port is six bits wide, so no other depth can be served.
    if (FILE_DEPTH != 64)
    begin : g_depth_check
        $error("FILE_DEPTH must be 64 for six-bit file addresses.");
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]  accumulator;
    logic        carry_flag;
    logic [7:0]  file_regs [FILE_DEPTH];
    logic [7:0]  special_regs [16];
    core_state_t state;
    logic        go;
    logic        special_ok;
    logic [7:0]  file_val;
    logic [7:0]  swapped;
    alu_if       alu ();

    // Instructions are ignored while halted; only wake or reset returns to run.
    assign go         = op_valid_i && (state == ST_RUN);
    assign special_ok = (special_sel_i >= `SPECIAL_SEL_MIN)
                        && (special_sel_i <= `SPECIAL_SEL_MAX);
    assign file_val   = file_regs[file_addr_i];
    assign swapped    = {file_val[3:0], file_val[7:4]};

    always_comb
    begin
        alu.cin = 1'b1;
        alu.a   = file_val;
        alu.b   = accumulator;
        if (op_i == OP_SUB_IMM_BRW)
        begin
            alu.a   = imm_i;
            alu.cin = carry_flag;
        end
    end

    sub_adder u_adder
    (
        .port (alu.slave)
    );

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            state <= ST_RUN;
        else if (go && op_i == OP_HALT_ENTRY)
            state <= ST_HALTED;
        else if (wake_i)
            state <= ST_RUN;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            accumulator <= `ACC_RESET;
        else if (go)
        begin
            case (op_i)
                OP_SUB_IMM_BRW:  accumulator <= alu.sum;
                OP_LOAD_SPECIAL:
                    if (special_ok)
                        accumulator <= special_regs[special_sel_i];
                OP_SUB_ACC_FILE:
                    if (!dest_file_i)
                        accumulator <= alu.sum;
                OP_NIBBLE_EXCH:
                    if (!dest_file_i)
                        accumulator <= swapped;
                default: ;
            endcase
        end
    end

    generate
        for (genvar i = 0; i < FILE_DEPTH; i++)
        begin : g_file
            always_ff @(posedge clk_sys_i or posedge rst_i)
            begin
                if (rst_i)
                    file_regs[i] <= `FILE_RESET;
                else if (go && dest_file_i && file_addr_i == 6'(i))
                begin
                    if (op_i == OP_SUB_ACC_FILE)
                        file_regs[i] <= alu.sum;
                    else if (op_i == OP_NIBBLE_EXCH)
                        file_regs[i] <= swapped;
                end
            end
        end
        for (genvar s = 0; s < 16; s++)
        begin : g_special
            always_ff @(posedge clk_sys_i or posedge rst_i)
            begin
                if (rst_i)
                    special_regs[s] <= `SPECIAL_RESET;
                else if (go && op_i == OP_STORE_SPEC && special_ok && special_sel_i == 4'(s))
                    special_regs[s] <= accumulator;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Moves and swaps leave the status flags alone.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            carry_flag         <= 1'b0;
            zero_flag_o        <= 1'b0;
            digit_carry_flag_o <= 1'b0;
        end
        else if (go && (op_i == OP_SUB_IMM_BRW || op_i == OP_SUB_ACC_FILE))
        begin
            carry_flag         <= alu.cout;
            digit_carry_flag_o <= alu.dc;
            zero_flag_o        <= (alu.sum == 8'h00);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            timeout_flag_n_o   <= `FLAG_TO_RESET;
            powerdown_flag_n_o <= `FLAG_PD_RESET;
        end
        else if (go && op_i == OP_HALT_ENTRY)
        begin
            timeout_flag_n_o   <= 1'b1;
            powerdown_flag_n_o <= 1'b0;
        end
    end

    // The watchdog itself lives elsewhere; this holds the cleared image and a pulse.
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wdt_clear_o          <= 1'b0;
            watchdog_count_o     <= `WDT_CLEAR;
            watchdog_prescaler_o <= `WDT_CLEAR;
        end
        else
        begin
            wdt_clear_o <= go && op_i == OP_HALT_ENTRY;
            if (go && op_i == OP_HALT_ENTRY)
            begin
                watchdog_count_o     <= `WDT_CLEAR;
                watchdog_prescaler_o <= `WDT_CLEAR;
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            illegal_op_o <= 1'b0;
        else
            illegal_op_o <= go && !special_ok
                            && (op_i == OP_LOAD_SPECIAL || op_i == OP_STORE_SPEC);
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            halted_o <= 1'b0;
        else
            halted_o <= (state == ST_HALTED && !wake_i) || (go && op_i == OP_HALT_ENTRY);
    end

    assign accumulator_o = accumulator;
    assign carry_flag_o  = carry_flag;
endmodule
`default_nettype wire

// file: subtract_swap_exec_chk.sv
// Assertion checker for the subtract, swap, special-move and halt execute block.
`timescale 1ns/1ps
`default_nettype none
module subtract_swap_exec_chk
    import exec_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic       op_valid_i,
    input wire op_t        op_i,
    input wire logic [7:0] imm_i,
    input wire logic       dest_file_i,
    input wire logic [7:0] accumulator_o,
    input wire logic       zero_flag_o,
    input wire logic       digit_carry_flag_o,
    input wire logic       carry_flag_o,
    input wire logic       timeout_flag_n_o,
    input wire logic       powerdown_flag_n_o,
    input wire logic       halted_o,
    input wire logic [7:0] watchdog_count_o,
    input wire logic [7:0] watchdog_prescaler_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    wire       go = op_valid_i && !halted_o;
    wire [2:0] fl = {zero_flag_o, digit_carry_flag_o, carry_flag_o};
    property p_sbc;
        go && op_i == OP_SUB_IMM_BRW |=> {carry_flag_o, accumulator_o} == {1'b0, $past(imm_i)}
            + {1'b0, ~$past(accumulator_o)} + 9'($past(carry_flag_o))
            && zero_flag_o == (accumulator_o == 8'h00);
    endproperty
    a_sbc: assert property (p_sbc) else $error("sub with borrow wrong");
    property p_dc;
        go && op_i == OP_SUB_IMM_BRW |=> digit_carry_flag_o == ({1'b0, $past(imm_i[3:0])}
            + {1'b0, ~$past(accumulator_o[3:0])} + 5'($past(carry_flag_o)) > 5'h0f);
    endproperty
    a_dc: assert property (p_dc) else $error("digit carry wrong");
    property p_load;
        go && op_i == OP_LOAD_SPECIAL |=> $stable(fl);
    endproperty
    a_load: assert property (p_load) else $error("load changed flags");
    property p_store;
        go && op_i == OP_STORE_SPEC |=> $stable(fl) && $stable(accumulator_o);
    endproperty
    a_store: assert property (p_store) else $error("store changed state");
    property p_wdt;
        go && op_i == OP_HALT_ENTRY |=> watchdog_count_o == 8'h00 && watchdog_prescaler_o == 8'h00;
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog not cleared");
    property p_halt;
        go && op_i == OP_HALT_ENTRY |=> timeout_flag_n_o && !powerdown_flag_n_o ##[0:1] halted_o;
    endproperty
    a_halt: assert property (p_halt) else $error("halt flags wrong");
    property p_subf;
        go && op_i == OP_SUB_ACC_FILE |=> ($past(dest_file_i) ? $stable(accumulator_o)
            : zero_flag_o == (accumulator_o == 8'h00));
    endproperty
    a_subf: assert property (p_subf) else $error("file subtract wrong");
    property p_swap;
        go && op_i == OP_NIBBLE_EXCH |=> $stable(fl) && ($stable(accumulator_o) || !$past(dest_file_i));
    endproperty
    a_swap: assert property (p_swap) else $error("swap changed state");
    c_sbc: cover property (go && op_i == OP_SUB_IMM_BRW ##1 carry_flag_o);
    c_halt: cover property (halted_o ##1 !halted_o);
    c_swap: cover property (go && op_i == OP_NIBBLE_EXCH && !dest_file_i);
endmodule
bind subtract_swap_exec subtract_swap_exec_chk chk (.*);
`default_nettype wire

// file: test_subtract_swap_exec.sv
// Self-checking bench for the subtract, swap, special-move and halt execute block.
`timescale 1ns/1ps
`default_nettype none
module test_subtract_swap_exec;
    import exec_pkg::*;
    logic clk_sys_i, rst_i, op_valid_i, dest_file_i, wake_i, zero_flag_o, digit_carry_flag_o;
    logic carry_flag_o, timeout_flag_n_o, powerdown_flag_n_o, halted_o, wdt_clear_o, illegal_op_o;
    op_t op_i;
    logic [7:0] imm_i, accumulator_o, watchdog_count_o, watchdog_prescaler_o, ea, ef, sv;
    logic [5:0] file_addr_i;
    logic [3:0] special_sel_i;
    logic [9:0] r;
    int num_errors = 0;
    int checks = 0;
    subtract_swap_exec dut (.*);
    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic op(input op_t o, input logic [7:0] i, input logic [3:0] s, input logic d);
        @(posedge clk_sys_i) #1;
        op_valid_i = 1'b1;
        op_i = o;
        imm_i = i;
        special_sel_i = s;
        dest_file_i = d;
        @(posedge clk_sys_i) #1;
        op_valid_i = 1'b0;
    endtask
    // Reference subtraction {digit carry, carry, result} of a + ~b + ci.
    function automatic logic [9:0] sub(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [4:0] lo;
        lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ci};
        sub = {lo[4], {1'b0, a} + {1'b0, ~b} + {8'h00, ci}};
    endfunction
    task automatic t_sbc;
        logic [7:0] imms [5];
        imms = '{8'h06, 8'h05, 8'h00, 8'hff, 8'h3c};
        foreach (imms[k])
        begin
            r = sub(imms[k], accumulator_o, carry_flag_o);
            op(OP_SUB_IMM_BRW, imms[k], 4'h0, 1'b0);
            chk(accumulator_o, r[7:0]);
            chk({zero_flag_o, digit_carry_flag_o, carry_flag_o}, {r[7:0] == 8'h00, r[9:8]});
        end
    endtask
    task automatic t_special;
        ea = accumulator_o;
        op(OP_STORE_SPEC, 8'h00, 4'h7, 1'b0);
        op(OP_SUB_IMM_BRW, 8'h77, 4'h0, 1'b0);
        sv = {zero_flag_o, digit_carry_flag_o, carry_flag_o};
        ef = accumulator_o;
        op(OP_STORE_SPEC, 8'h00, 4'h3, 1'b0);
        chk(illegal_op_o, 1'b1);
        op(OP_STORE_SPEC, 8'h00, 4'hf, 1'b0);
        op(OP_LOAD_SPECIAL, 8'h00, 4'h7, 1'b0);
        chk(accumulator_o, ea);
        chk({zero_flag_o, digit_carry_flag_o, carry_flag_o}, sv);
        op(OP_LOAD_SPECIAL, 8'h00, 4'hf, 1'b0);
        chk(accumulator_o, ef);
    endtask
    task automatic t_file;
        ea = accumulator_o;
        r = sub(8'h00, ea, 1'b1);
        ef = r[7:0];
        op(OP_SUB_ACC_FILE, 8'h00, 4'h0, 1'b1);
        chk(accumulator_o, ea);
        r = sub(ef, ea, 1'b1);
        op(OP_SUB_ACC_FILE, 8'h00, 4'h0, 1'b0);
        chk({digit_carry_flag_o, carry_flag_o, accumulator_o}, r);
        chk(zero_flag_o, r[7:0] == 8'h00);
        sv = {zero_flag_o, digit_carry_flag_o, carry_flag_o};
        op(OP_NIBBLE_EXCH, 8'h00, 4'h0, 1'b0);
        chk(accumulator_o, {ef[3:0], ef[7:4]});
        // Swapping into the file and back again must restore the original byte.
        op(OP_NIBBLE_EXCH, 8'h00, 4'h0, 1'b1);
        op(OP_NIBBLE_EXCH, 8'h00, 4'h0, 1'b0);
        chk(accumulator_o, ef);
        chk({zero_flag_o, digit_carry_flag_o, carry_flag_o}, sv);
    endtask
    task automatic t_halt;
        ea = accumulator_o;
        op(OP_HALT_ENTRY, 8'h00, 4'h0, 1'b0);
        chk({wdt_clear_o, watchdog_count_o, watchdog_prescaler_o}, 17'h1_0000);
        chk({timeout_flag_n_o, powerdown_flag_n_o}, 2'b10);
        @(posedge clk_sys_i);
        op(OP_SUB_IMM_BRW, 8'h12, 4'h0, 1'b0);
        chk({halted_o, accumulator_o}, {1'b1, ea});
        wake_i = 1'b1;
        @(posedge clk_sys_i) #1;
        wake_i = 1'b0;
        chk(halted_o, 1'b0);
        repeat (2) @(posedge clk_sys_i);
    endtask
    task automatic t_reset;
        @(posedge clk_sys_i) #1;
        rst_i = 1'b1;
        @(posedge clk_sys_i) #1;
        chk({accumulator_o, timeout_flag_n_o, powerdown_flag_n_o, halted_o}, 11'h006);
        rst_i = 1'b0;
        op(OP_SUB_IMM_BRW, 8'h06, 4'h0, 1'b0);
        chk(accumulator_o, 8'h05);
    endtask
    task automatic complete_run;
        if (num_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #20us;
        num_errors++;
        complete_run();
    end
    initial
    begin
        rst_i = 1'b1;
        op_valid_i = 1'b0;
        op_i = OP_NONE;
        imm_i = 8'h00;
        dest_file_i = 1'b0;
        special_sel_i = 4'h0;
        wake_i = 1'b0;
        file_addr_i = 6'h05;
        repeat (8) @(posedge clk_sys_i);
        #1 rst_i = 0;
        t_sbc();
        t_special();
        t_file();
        t_halt();
        t_reset();
        complete_run();
    end
endmodule
`default_nettype wire
